// File: logic/spp_buf.sv
`include "spp_params.svh"
// two-entry buffer; a stalled reader holds the writer off
module spp_buf (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [`SPP_WORD_W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [`SPP_WORD_W-1:0] out_data_o
);
    logic [`SPP_WORD_W-1:0] mem_reg [`SPP_BUF_DEPTH];
    logic [`SPP_WORD_W-1:0] mem_next [`SPP_BUF_DEPTH];
    logic wr_reg, wr_next, rd_reg, rd_next;
    logic [1:0] cnt_reg, cnt_next;
    logic push, pop;

    // pointer and count update
    always_comb begin
        push = in_valid_i && (cnt_reg != 2'(`SPP_BUF_DEPTH));
        pop = out_valid_o && out_ready_i;
        mem_next = mem_reg;
        wr_next = wr_reg;
        rd_next = rd_reg;
        cnt_next = cnt_reg;
        if (push) begin
            mem_next[wr_reg] = in_data_i;
            wr_next = !wr_reg;
        end
        if (pop) begin
            rd_next = !rd_reg;
        end
        if (push && !pop) begin
            cnt_next = cnt_reg + 2'h1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 2'h1;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mem_reg <= '{default: '0};
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
            cnt_reg <= 2'h0;
        end else begin
            mem_reg <= mem_next;
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    assign in_ready_o = (cnt_reg != 2'(`SPP_BUF_DEPTH));
    assign out_valid_o = (cnt_reg != 2'h0);
    assign out_data_o = mem_reg[rd_reg];
endmodule : spp_buf

// File: logic/spp_core.sv
`include "spp_params.svh"
// Operation
// - one clock cycle per shifted bit
// - master clock runs only during word
// - slave ignores clock while select high
// - launch one edge, sample the other
// - polarity and phase pick transfer format
// - master drives clock, selectable rate
// - select low means chip selected
// - select low as master flags error
// - mosi out as master, in as slave
// - miso in as master, out as slave
// - open drain option on miso
// - bit 5 disables miso drive
// - flag outputs may select slave processor
// - each flag pin can be slave select
module spp_core (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [`SPP_CTL_W-1:0] port_control_reg_i,
    input wire logic [`SPP_DIV_W-1:0] rate_div_i,
    input wire logic [`SPP_FLAG_N-1:0] flag_select_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic [`SPP_WORD_W-1:0] tx_data_i,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    output logic [`SPP_WORD_W-1:0] rx_data_o,
    output logic busy_o,
    output logic multimaster_err_o,
    input wire logic err_clear_i,
    input wire logic serial_shift_clock_i,
    output logic serial_shift_clock_o,
    output logic serial_shift_clock_oe_o,
    input wire logic device_select_in_n_i,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_o,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_o,
    output logic [`SPP_FLAG_N-1:0] flag_slave_select_out_n_o,
    output logic [`SPP_FLAG_N-1:0] flag_slave_select_out_oe_o
);
    logic cpol, cpha, mstr, open_drain_enable, en, slave_out_disable;
    spp_pkg::spp_state_t st_reg, st_next;
    logic [`SPP_WORD_W-1:0] sh_reg, sh_next, rxd_reg, rxd_next;
    logic [`SPP_BIT_CNT_W-1:0] bit_reg, bit_next;
    logic [`SPP_DIV_W-1:0] div_reg, div_next;
    logic sck_reg, sck_next, err_reg, err_next, rxv_reg, rxv_next;
    logic ss_reg, ss_next, out_reg, out_next;
    logic [2:0] sclk_s_reg, ds_s_reg;
    logic [1:0] mosi_s_reg, miso_s_reg;
    logic sclk_rise, sclk_fall, s_lead, s_trail, sin, sel_n, rx_ready;
    logic sel_end;

    // control fields from the port control word
    always_comb begin
        cpol = port_control_reg_i[`SPP_CTL_CPOL];
        cpha = port_control_reg_i[`SPP_CTL_CPHA];
        mstr = port_control_reg_i[`SPP_CTL_MSTR];
        open_drain_enable = port_control_reg_i[`SPP_CTL_OPD];
        en = port_control_reg_i[`SPP_CTL_EN];
        slave_out_disable = port_control_reg_i[`SPP_CTL_SLAVE_OUT_DISABLE];
    end

    // pin synchronisers; stage 0 only feeds stage 1
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_s_reg <= 3'h0;
            ds_s_reg <= 3'h7;
            mosi_s_reg <= 2'h0;
            miso_s_reg <= 2'h0;
        end else begin
            sclk_s_reg <= {sclk_s_reg[1:0], serial_shift_clock_i};
            ds_s_reg <= {ds_s_reg[1:0], device_select_in_n_i};
            mosi_s_reg <= {mosi_s_reg[0], mosi_i};
            miso_s_reg <= {miso_s_reg[0], miso_i};
        end
    end

    // slave edges are masked while select is high
    always_comb begin
        sel_n = ds_s_reg[1];
        // only a release of select aborts; a taken word may wait for select
        sel_end = ds_s_reg[1] && !ds_s_reg[2];
        sclk_rise = sclk_s_reg[1] && !sclk_s_reg[2];
        sclk_fall = !sclk_s_reg[1] && sclk_s_reg[2];
        // leading edge depends on polarity
        s_lead = !sel_n && (cpol ? sclk_fall : sclk_rise);
        s_trail = !sel_n && (cpol ? sclk_rise : sclk_fall);
        // miso reaches the master two cycles late: divider needs two or more
        sin = mstr ? miso_s_reg[1] : mosi_s_reg[1];
    end

    // transfer engine; master ticks from divider, slave from pin edges
    always_comb begin
        st_next = st_reg;
        sh_next = sh_reg;
        rxd_next = rxd_reg;
        bit_next = bit_reg;
        div_next = div_reg;
        sck_next = sck_reg;
        err_next = err_reg;
        rxv_next = rxv_reg && !rx_ready;
        ss_next = ss_reg;
        out_next = out_reg;
        tx_ready_o = 1'b0;
        if (mstr && en && !sel_n) begin
            err_next = 1'b1;
        end else if (err_clear_i) begin
            err_next = 1'b0; // set wins over clear
        end
        case (st_reg)
            spp_pkg::SPP_IDLE: begin
                sck_next = cpol;
                ss_next = 1'b0;
                div_next = rate_div_i;
                bit_next = `SPP_BITS_PER_WORD;
                if (en && tx_valid_i && (!mstr || !err_reg)) begin
                    tx_ready_o = 1'b1;
                    sh_next = tx_data_i;
                    out_next = tx_data_i[`SPP_WORD_W-1];
                    ss_next = mstr;
                    st_next = spp_pkg::SPP_LEAD;
                end
            end
            spp_pkg::SPP_LEAD: begin
                // first half bit: phase 1 launches here
                if (mstr) begin
                    div_next = div_reg - `SPP_DIV_W'(1);
                end
                if (mstr ? (div_reg == '0) : s_lead) begin
                    div_next = rate_div_i;
                    if (mstr) begin
                        sck_next = !cpol;
                    end
                    if (cpha) begin
                        out_next = sh_reg[`SPP_WORD_W-1];
                    end else begin
                        sh_next = {sh_reg[`SPP_WORD_W-2:0], sin};
                    end
                    st_next = spp_pkg::SPP_TRAIL;
                end
                if (!mstr && sel_end) begin
                    st_next = spp_pkg::SPP_IDLE;
                end
            end
            spp_pkg::SPP_TRAIL: begin
                if (mstr) begin
                    div_next = div_reg - `SPP_DIV_W'(1);
                end
                if (mstr ? (div_reg == '0) : s_trail) begin
                    div_next = rate_div_i;
                    if (mstr) begin
                        sck_next = cpol;
                    end
                    if (cpha) begin
                        sh_next = {sh_reg[`SPP_WORD_W-2:0], sin};
                    end else begin
                        out_next = sh_reg[`SPP_WORD_W-1];
                    end
                    bit_next = bit_reg - `SPP_BIT_CNT_W'(1);
                    st_next = (bit_reg == `SPP_BIT_CNT_W'(1)) ?
                        spp_pkg::SPP_DONE : spp_pkg::SPP_LEAD;
                end
                if (!mstr && sel_end) begin
                    st_next = spp_pkg::SPP_IDLE;
                end
            end
            default: begin
                // hand the word on; waits while buffer is full
                if (rx_ready) begin
                    rxd_next = sh_reg;
                    rxv_next = 1'b1;
                    ss_next = 1'b0;
                    st_next = spp_pkg::SPP_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg <= spp_pkg::SPP_IDLE;
            sh_reg <= '0;
            rxd_reg <= '0;
            bit_reg <= '0;
            div_reg <= `SPP_DIV_RST;
            sck_reg <= 1'b0;
            err_reg <= 1'b0;
            rxv_reg <= 1'b0;
            ss_reg <= 1'b0;
            out_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            sh_reg <= sh_next;
            rxd_reg <= rxd_next;
            bit_reg <= bit_next;
            div_reg <= div_next;
            sck_reg <= sck_next;
            err_reg <= err_next;
            rxv_reg <= rxv_next;
            ss_reg <= ss_next;
            out_reg <= out_next;
        end
    end

    // receive buffer so a stalled reader loses no word
    spp_buf u_rx_buf (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .in_valid_i(rxv_reg),
        .in_ready_o(rx_ready),
        .in_data_i(rxd_reg),
        .out_valid_o(rx_valid_o),
        .out_ready_i(rx_ready_i),
        .out_data_o(rx_data_o)
    );

    // pin drivers; direction follows role
    always_comb begin
        serial_shift_clock_o = sck_reg;
        serial_shift_clock_oe_o = mstr && en;
        mosi_o = out_reg;
        mosi_oe_o = mstr && en;
        // open drain drives low only
        miso_o = open_drain_enable ? 1'b0 : out_reg;
        miso_oe_o = !mstr && en && !sel_n && !slave_out_disable
            && (!open_drain_enable || !out_reg);
        // any chosen flag drives select low in a word as master; as slave ss_reg stays low
        flag_slave_select_out_n_o = ~(flag_select_i & {`SPP_FLAG_N{ss_reg}});
        flag_slave_select_out_oe_o = flag_select_i;
        busy_o = (st_reg != spp_pkg::SPP_IDLE);
        multimaster_err_o = err_reg;
    end
endmodule : spp_core

// File: shared/spp_params.svh
`ifndef SPP_PARAMS_SVH
`define SPP_PARAMS_SVH
// port control bit positions
`define SPP_CTL_W 8
`define SPP_CTL_CPOL 0
`define SPP_CTL_CPHA 1
`define SPP_CTL_MSTR 2
`define SPP_CTL_OPD 3
`define SPP_CTL_EN 4
`define SPP_CTL_SLAVE_OUT_DISABLE 5
`define SPP_CTL_RST 8'h00
// word, clock divider, flag count and buffer depth
`define SPP_WORD_W 8
`define SPP_BIT_CNT_W 4
`define SPP_BITS_PER_WORD 4'h8
`define SPP_DIV_W 8
`define SPP_DIV_RST 8'h01
`define SPP_FLAG_N 4
`define SPP_BUF_DEPTH 2
`endif

// File: shared/spp_pkg.sv
package spp_pkg;
    typedef enum logic [1:0] {
        SPP_IDLE = 2'b00,
        SPP_LEAD = 2'b01,
        SPP_TRAIL = 2'b10,
        SPP_DONE = 2'b11
    } spp_state_t;
endpackage : spp_pkg

// File: tb/spp_core_checker.sv
`include "spp_params.svh"
// role, clock gating and error relations at the core's pins
module spp_core_checker (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [`SPP_CTL_W-1:0] port_control_reg_i,
    input wire logic busy_o,
    input wire logic tx_ready_o,
    input wire logic multimaster_err_o,
    input wire logic err_clear_i,
    input wire logic device_select_in_n_i,
    input wire logic serial_shift_clock_o,
    input wire logic serial_shift_clock_oe_o,
    input wire logic mosi_oe_o,
    input wire logic miso_o,
    input wire logic miso_oe_o
);
    logic [`SPP_CTL_W-1:0] c;
    logic m, me;
    // short aliases; direction checks allow one cycle after a role change, the clock drive check two
    assign c = port_control_reg_i;
    assign m = c[`SPP_CTL_MSTR];
    assign me = m & c[`SPP_CTL_EN];
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    idle_clock_a: assert property (
        me && !busy_o ##1 me && !busy_o && $stable(c)
        |-> serial_shift_clock_o == c[`SPP_CTL_CPOL]) else $error("idle");
    clock_drive_a: assert property (
        me [*3] |-> serial_shift_clock_oe_o) else $error("sclk oe");
    slave_pins_a: assert property (
        !m [*2] |-> !mosi_oe_o && !serial_shift_clock_oe_o) else $error("dir");
    master_miso_a: assert property (
        m [*2] |-> !miso_oe_o) else $error("miso oe");
    miso_off_a: assert property (
        c[`SPP_CTL_SLAVE_OUT_DISABLE] [*2] |-> !miso_oe_o) else $error("miso off");
    open_drain_a: assert property (
        c[`SPP_CTL_OPD] && miso_oe_o |-> !miso_o) else $error("drain");
    err_set_a: assert property (
        (me && !device_select_in_n_i) [*3] |-> ##[0:2] multimaster_err_o)
        else $error("err set");
    err_hold_a: assert property (
        multimaster_err_o && !err_clear_i |=> multimaster_err_o)
        else $error("err hold");
    tx_refuse_a: assert property (
        m && multimaster_err_o |-> !tx_ready_o) else $error("refuse");
    cover property (me && $fell(busy_o));
    cover property (multimaster_err_o);
    cover property (!m && !device_select_in_n_i && c[`SPP_CTL_SLAVE_OUT_DISABLE]);
endmodule : spp_core_checker
bind spp_core spp_core_checker chk_u (.*);

// File: tb/spp_slave_model.sv
// far-end slave: selected low, shifts msb first, lets miso float when idle
module spp_slave_model (
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    input wire logic cpol_i,
    input wire logic cpha_i,
    input wire logic [7:0] tx_i,
    output logic miso_o,
    output logic [7:0] rx_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int k = 8;
    logic [7:0] sh;
    // reload on select; phase 1 shows no bit until the first leading edge
    always @(negedge cs_n_i) begin
        sh = tx_i;
        k = cpha_i ? -1 : 0;
    end
    // launch edge moves to the next bit, the other edge samples mosi
    always @(sclk_i) begin
        if (!cs_n_i && !(sclk_i ^ cpol_i ^ cpha_i))
            k++;
        else if (!cs_n_i)
            rx_o = {rx_o[6:0], mosi_i};
    end
    // unselected or finished: the pull-up wins
    assign miso_o = (cs_n_i || k < 0 || k > 7) ? 1'b1 : sh[7 - k];
endmodule : spp_slave_model

// File: tb/tb_spp_core.sv
module tb_spp_core;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_i = 1'b0, rst_i = 1'b1, tx_valid_i = 1'b0, rx_ready_i = 1'b0;
    logic err_clear_i = 1'b0, device_select_in_n_i = 1'b1;
    logic tb_sclk = 1'b0, tb_mosi = 1'b0, s_miso;
    logic [7:0] port_control_reg_i = 8'h00, rate_div_i = 8'h01, got, s_rx;
    logic [7:0] tx_data_i = 8'h00, s_tx = 8'h00, rx_data_o;
    logic [3:0] flag_select_i = 4'h1;
    logic [3:0] flag_slave_select_out_n_o, flag_slave_select_out_oe_o;
    logic tx_ready_o, rx_valid_o, busy_o, multimaster_err_o, miso_o;
    logic serial_shift_clock_o, serial_shift_clock_oe_o, mosi_o, mosi_oe_o;
    logic miso_oe_o;
    int err_count = 0, check_count = 0, rises = 0;
    // each wire takes whoever enables its driver
    wire serial_shift_clock_i = serial_shift_clock_oe_o ?
        serial_shift_clock_o : tb_sclk;
    wire mosi_i = mosi_oe_o ? mosi_o : tb_mosi;
    wire miso_i = miso_oe_o ? miso_o : s_miso;
    spp_core dut_u (.*);
    spp_slave_model slv_u (.sclk_i(serial_shift_clock_i),
        .cs_n_i(flag_slave_select_out_n_o[0]), .mosi_i(mosi_i),
        .cpol_i(port_control_reg_i[0]), .cpha_i(port_control_reg_i[1]),
        .tx_i(s_tx), .miso_o(s_miso), .rx_o(s_rx));
    always #20 mclk_i = ~mclk_i;
    always @(posedge serial_shift_clock_i) rises++;
    task automatic chk(input string n, input logic [7:0] e, g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // hold the word until taken; as master also wait for the word to end
    task automatic send(input logic [7:0] w);
        int n = 0;
        logic rdy;
        tx_valid_i <= 1'b1;
        tx_data_i <= w;
        // look at ready between edges, then let the taking edge pass
        do begin
            @(negedge mclk_i);
            rdy = tx_ready_o;
            @(posedge mclk_i);
        end while (rdy !== 1'b1 && ++n < 500);
        wait_limit(n, 500);
        tx_valid_i <= 1'b0;
        n = 0;
        do @(negedge mclk_i);
        while (port_control_reg_i[2] && busy_o !== 1'b0 && ++n < 2000);
        wait_limit(n, 2000);
        @(posedge mclk_i);
    endtask : send
    // valid is read off the edge; ready is held over one rising edge
    task automatic get_rx(input logic [7:0] e);
        int n = 0;
        do @(negedge mclk_i); while (rx_valid_o !== 1'b1 && ++n < 500);
        wait_limit(n, 500);
        chk("rx data", e, rx_data_o);
        @(posedge mclk_i);
        rx_ready_i <= 1'b1;
        @(posedge mclk_i);
        rx_ready_i <= 1'b0;
    endtask : get_rx
    // outside master, format 0, 320 ns per bit, clock still between frames
    task automatic sxfer(input logic [7:0] w, input logic sn,
            output logic [7:0] r);
        device_select_in_n_i <= sn;
        for (int b = 7; b >= 0; b--) begin
            tb_mosi <= w[b];
            repeat (4) @(posedge mclk_i);
            r[b] = miso_i;
            tb_sclk <= 1'b1;
            repeat (4) @(posedge mclk_i);
            tb_sclk <= 1'b0;
        end
        repeat (4) @(posedge mclk_i);
        device_select_in_n_i <= 1'b1;
    endtask : sxfer
    // a handshake that never comes ends the run as a failure
    task automatic wait_limit(input int n, input int m);
        if (n >= m) begin
            err_count++;
            $display("CHECK FAILED wait exp below %0d got %0d", m, n);
            end_sim;
        end
    endtask : wait_limit
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    initial begin
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        // every clock format as master, two words left in the buffer
        for (int i = 0; i < 4; i++) begin
            port_control_reg_i <= 8'h14 | 8'(i);
            rate_div_i <= 8'(i + 2); // miso synchroniser needs two or more
            s_tx <= 8'h3C ^ 8'(i);
            repeat (4) @(posedge mclk_i);
            rises = 0;
            send(8'hA5 ^ 8'(i));
            chk("slave rx", 8'hA5 ^ 8'(i), s_rx);
            chk("rises", 8'h08, 8'(rises));
            send(8'h0F);
            get_rx(8'h3C ^ 8'(i));
            get_rx(8'h3C ^ 8'(i));
        end
        chk("flag oe", 8'h01, 8'(flag_slave_select_out_oe_o));
        $display("test master done");
        device_select_in_n_i <= 1'b0;
        repeat (5) @(posedge mclk_i);
        device_select_in_n_i <= 1'b1;
        tx_valid_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        chk("error", 8'h01, 8'(multimaster_err_o));
        chk("refused", 8'h00, 8'(tx_ready_o));
        tx_valid_i <= 1'b0;
        err_clear_i <= 1'b1;
        @(posedge mclk_i);
        err_clear_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        chk("cleared", 8'h00, 8'(multimaster_err_o));
        $display("test error done");
        port_control_reg_i <= 8'h18;
        send(8'h96);
        sxfer(8'h5A, 1'b0, got);
        chk("slave tx", 8'h96, got);
        get_rx(8'h5A);
        // a word waits in the slave; unselected clocks must not move it
        send(8'h96);
        sxfer(8'h77, 1'b1, got);
        chk("ignored", 8'h00, 8'(rx_valid_o));
        chk("held", 8'h01, 8'(busy_o));
        port_control_reg_i <= 8'h30;
        sxfer(8'hC3, 1'b0, got);
        chk("miso off", 8'hFF, got);
        get_rx(8'hC3);
        $display("test slave done");
        end_sim;
    end
    // run needs under a thousand cycles; this is far past that
    initial begin
        #200000;
        err_count++;
        end_sim;
    end
endmodule : tb_spp_core
